// ---- hw/single_wire_bus_master.sv ----
// Single-wire open-drain bus master sequencer
`timescale 1ns/1ps
`default_nettype none
module single_wire_bus_master
  import swire_pkg::*;
#(
  parameter int RESET_COUNT = RESET_CYCLES,
  parameter int PRESENCE_COUNT = PRESENCE_CYCLES,
  parameter int SLOT_COUNT = SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] mode,
  input wire logic readOp,
  input wire logic checkPresence,
  input wire logic [7:0] itemCount,
  output logic busy,
  output logic done,
  output logic noPresence,
  input wire logic itemValid,
  input wire logic [7:0] itemData,
  output logic itemReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic [7:0] rxIndex,
  input wire logic dqIn,
  output logic dqOut,
  output logic dqOe
);
  // Reset synchroniser stages
  logic rstSync1;
  logic rstSync2;

  // Sequencer state and slot timer
  state_type state;
  logic [CNT_WIDTH-1:0] timer;

  // Request fields held for the whole operation
  logic [2:0] modeReg;
  logic readReg;
  logic checkReg;
  logic [7:0] countReg;

  // Item progress and bit shifter
  logic [7:0] itemsDone;
  logic [7:0] shiftReg;
  logic [2:0] bitIdx;

  // Line observations
  logic presenceSeen;
  logic sampled;

  // Slot timer has run out
  logic timerEnd;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // Last bit of current item
  function automatic logic lastBit(input logic [2:0] m, input logic [2:0] b);
    lastBit = m[MODE_BIT_MODE_BIT] || (b == 3'h7);
  endfunction : lastBit

  assign timerEnd = (timer == '0);
  // Write items accepted at start of an item
  assign itemReady = (state == WAIT_ITEM) && !readReg;
  assign busy = (state != IDLE);

  // Open-drain pin: drive low or release
  always_comb begin
    dqOut = 1'b0;
    dqOe = 1'b0;
    unique case (state)
      PRE_RESET_LOW, POST_RESET_LOW: dqOe = 1'b1;
      SLOT_LOW: dqOe = 1'b1;
      SLOT_HOLD: dqOe = !readReg && !shiftReg[0];
      default: dqOe = 1'b0;
    endcase
  end

  // Request capture
  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      modeReg <= 3'h0;
      readReg <= 1'b0;
      checkReg <= 1'b0;
      countReg <= 8'h00;
    end else if (state == IDLE && start) begin
      modeReg <= mode;
      readReg <= readOp;
      checkReg <= checkPresence;
      countReg <= itemCount;
    end
  end

  // Main sequencer with slot timer
  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      state <= IDLE;
      timer <= '0;
      itemsDone <= 8'h00;
      bitIdx <= 3'h0;
      shiftReg <= 8'h00;
      presenceSeen <= 1'b0;
      sampled <= 1'b0;
    end else begin
      if (!timerEnd) begin
        timer <= timer - 1'b1;
      end
      unique case (state)

        // Wait for a request; reset first if asked
        // Progress and presence start clean each time
        IDLE: begin
          if (start) begin
            itemsDone <= 8'h00;
            bitIdx <= 3'h0;
            presenceSeen <= 1'b0;
            if (mode[MODE_RESET_BEFORE_BIT]) begin
              state <= PRE_RESET_LOW;
              timer <= CNT_WIDTH'(RESET_COUNT);
            end else begin
              state <= WAIT_ITEM;
            end
          end
        end

        // Reset pulse: line held low for the reset count
        // Presence only counts after the line is released
        PRE_RESET_LOW, POST_RESET_LOW: begin
          presenceSeen <= 1'b0;
          if (timerEnd) begin
            state <= (state == PRE_RESET_LOW) ? PRE_RESET_WAIT
                                              : POST_RESET_WAIT;
            timer <= CNT_WIDTH'(PRESENCE_COUNT);
          end
        end

        // Presence window: any low level marks a slave
        // Line is released here, slaves pull it down
        PRE_RESET_WAIT, POST_RESET_WAIT: begin
          if (!dqIn) begin
            presenceSeen <= 1'b1;
          end
          if (timerEnd) begin
            state <= (state == PRE_RESET_WAIT) ? PRE_RESET_REST
                                               : POST_RESET_REST;
            timer <= CNT_WIDTH'(RESET_COUNT - PRESENCE_COUNT);
          end
        end

        // Rest of the reset period before the data phase
        // Abort here when presence was required but absent
        PRE_RESET_REST: begin
          if (timerEnd) begin
            if (checkReg && !presenceSeen) begin
              state <= IDLE;
            end else begin
              state <= WAIT_ITEM;
            end
          end
        end

        // Rest after the closing reset, then back to idle
        // No presence check on the closing reset
        POST_RESET_REST: begin
          if (timerEnd) begin
            state <= IDLE;
          end
        end

        // Between items: finish, or load the next item
        // Write items wait for the requester's valid
        WAIT_ITEM: begin
          if (itemsDone == countReg) begin
            if (modeReg[MODE_RESET_AFTER_BIT]) begin
              state <= POST_RESET_LOW;
              timer <= CNT_WIDTH'(RESET_COUNT);
            end else begin
              state <= IDLE;
            end
          end else if (readReg || itemValid) begin
            shiftReg <= readReg ? 8'h00 : itemData;
            bitIdx <= 3'h0;
            state <= SLOT_LOW;
            timer <= CNT_WIDTH'(readReg ? READ_LOW_CYCLES : WRITE_LOW_CYCLES);
          end
        end

        // Opening low of every slot
        // Short for reads, longer for writes
        SLOT_LOW: begin
          if (timerEnd) begin
            state <= SLOT_HOLD;
            timer <= CNT_WIDTH'(readReg
              ? READ_SAMPLE_CYCLES - READ_LOW_CYCLES
              : SLOT_COUNT - WRITE_LOW_CYCLES);
          end
        end

        // Hold phase: zero bits keep the line low
        // Reads let slaves drive and sample at the end
        SLOT_HOLD: begin
          if (timerEnd) begin
            // Sample within limit after falling edge
            sampled <= dqIn;
            state <= SLOT_RECOVER;
            timer <= CNT_WIDTH'(readReg
              ? SLOT_COUNT - READ_SAMPLE_CYCLES + RECOVER_CYCLES
              : RECOVER_CYCLES);
          end
        end

        // Released recovery gap, then next bit or item
        // Shift happens once per bit, at the gap's end
        SLOT_RECOVER: begin
          if (timerEnd) begin
            // LSB first shift, bits enter at the top
            shiftReg <= readReg ? {sampled, shiftReg[7:1]}
                                : {1'b0, shiftReg[7:1]};
            if (lastBit(modeReg, bitIdx)) begin
              itemsDone <= itemsDone + 8'h01;
              state <= WAIT_ITEM;
            end else begin
              bitIdx <= bitIdx + 3'h1;
              state <= SLOT_LOW;
              timer <= CNT_WIDTH'(readReg ? READ_LOW_CYCLES
                                          : WRITE_LOW_CYCLES);
            end
          end
        end

        // Unused state codes fall back to idle
        default: state <= IDLE;
      endcase
    end
  end

  // Completion, error and receive outputs
  always_ff @(posedge ref_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      done <= 1'b0;
      noPresence <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxIndex <= 8'h00;
    end else begin
      done <= 1'b0;
      rxValid <= 1'b0;
      if (state == IDLE && start) begin
        noPresence <= 1'b0;
      end

      // Abort flag stands until the next request
      if (state == PRE_RESET_REST && timerEnd && checkReg && !presenceSeen) begin
        noPresence <= 1'b1;
        done <= 1'b1;
      end

      // End of closing reset completes the operation
      if (state == POST_RESET_REST && timerEnd) begin
        done <= 1'b1;
      end

      // Last item without closing reset completes it
      if (state == WAIT_ITEM && itemsDone == countReg
          && !modeReg[MODE_RESET_AFTER_BIT]) begin
        done <= 1'b1;
      end

      // Received item handed over at its last bit
      if (state == SLOT_RECOVER && timerEnd && readReg
          && lastBit(modeReg, bitIdx)) begin
        rxValid <= 1'b1;
        rxIndex <= itemsDone;
        // One bit per item in bit mode
        rxData <= modeReg[MODE_BIT_MODE_BIT] ? {7'h00, sampled}
                                             : {sampled, shiftReg[7:1]};
      end
    end
  end
endmodule : single_wire_bus_master
`default_nettype wire

// ---- include/swire_pkg.sv ----
// Package with timing counts and mode fields for the single-wire master
package swire_pkg;
  localparam int CLK_MHZ = 40;
  localparam int RESET_US = 480;
  localparam int PRESENCE_WAIT_US = 70;
  localparam int SLOT_US = 60;
  localparam int WRITE_LOW_US = 6;
  localparam int ZERO_LOW_US = 60;
  localparam int READ_LOW_US = 2;
  localparam int READ_SAMPLE_US = 12;
  localparam int RECOVER_US = 2;
  localparam int READ_SAMPLE_LIMIT_US = 15;
  localparam int RESET_CYCLES = RESET_US * CLK_MHZ;
  localparam int PRESENCE_CYCLES = PRESENCE_WAIT_US * CLK_MHZ;
  localparam int SLOT_CYCLES = SLOT_US * CLK_MHZ;
  localparam int WRITE_LOW_CYCLES = WRITE_LOW_US * CLK_MHZ;
  localparam int READ_LOW_CYCLES = READ_LOW_US * CLK_MHZ;
  localparam int READ_SAMPLE_CYCLES = READ_SAMPLE_US * CLK_MHZ;
  localparam int RECOVER_CYCLES = RECOVER_US * CLK_MHZ;
  localparam int MODE_RESET_BEFORE_BIT = 0;
  localparam int MODE_RESET_AFTER_BIT = 1;
  localparam int MODE_BIT_MODE_BIT = 2;
  localparam int CNT_WIDTH = 16;
  typedef enum logic [3:0] {
    IDLE, PRE_RESET_LOW, PRE_RESET_WAIT, PRE_RESET_REST, WAIT_ITEM,
    SLOT_LOW, SLOT_HOLD, SLOT_RECOVER, POST_RESET_LOW, POST_RESET_WAIT,
    POST_RESET_REST
  } state_type;
endpackage : swire_pkg

// ---- tb/swire_monitor.sv ----
// Port checker for the single-wire master
`timescale 1ns/1ps
`default_nettype none
module swire_monitor #(
  parameter int RESET_COUNT = 1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] mode,
  input wire logic readOp,
  input wire logic busy,
  input wire logic done,
  input wire logic noPresence,
  input wire logic itemReady,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic dqOut,
  input wire logic dqOe
);
  int lowCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Length of the current driven-low stretch
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) lowCnt <= 0;
    else lowCnt <= dqOe ? lowCnt + 1 : 0;
  low_level_a:
    assert property (dqOut == 1'b0) else $error("pin drives high");
  idle_release_a:
    assert property (!busy |-> !dqOe) else $error("pin held while idle");
  done_release_a:
    assert property (done |-> !dqOe) else $error("pin held at end");
  start_busy_a:
    assert property (start && !busy |=> busy) else $error("start lost");
  rx_pulse_a:
    assert property (rxValid |=> !rxValid) else $error("item pulse long");
  bit_item_a:
    assert property (rxValid && mode[2] |-> rxData[7:1] == 7'h00)
      else $error("bit item too wide");
  abort_flag_a:
    assert property ($rose(noPresence) |-> done) else $error("abort late");
  reset_width_a:
    assert property (lowCnt <= RESET_COUNT + 1) else $error("low too long");
  item_write_a:
    assert property (itemReady |-> !readOp) else $error("item on read");
  done_c: cover property (done);
  abort_c: cover property ($rose(noPresence));
  bit_c: cover property (rxValid && mode[2]);
endmodule : swire_monitor
bind single_wire_bus_master swire_monitor #(.RESET_COUNT(RESET_COUNT))
  swire_monitor_i (.*);
`default_nettype wire

// ---- tb/swire_slave.sv ----
// Behavioural slave on the shared line
`timescale 1ns/1ps
`default_nettype none
module swire_slave (
  input wire logic ref_clk,
  input wire logic dqIn,
  input wire logic talk,
  input wire logic present,
  input wire logic [7:0] txByte,
  output logic pull,
  output logic [7:0] gotByte
);
  int bitNo;
  int lowLen;
  // Each fall opens a slot; a long low is a reset
  initial begin
    pull = 0;
    bitNo = 0;
    gotByte = 8'h00;
    forever begin
      @(negedge dqIn);
      pull = talk && !txByte[bitNo];
      repeat (600) @(posedge ref_clk);
      gotByte[bitNo] = dqIn;
      bitNo = (bitNo + 1) % 8;
      pull = 0;
      lowLen = 600;
      #1;
      while (!dqIn) begin
        @(posedge ref_clk);
        lowLen++;
      end
      if (lowLen > 3000) begin
        bitNo = 0;
        repeat (60) @(posedge ref_clk);
        pull = present;
        repeat (400) @(posedge ref_clk);
        pull = 0;
      end
    end
  end
endmodule : swire_slave
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the single-wire master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, rst_b = 0, start = 0, readOp = 0, itemValid = 0;
  logic checkPresence = 1, talk = 0, present = 1;
  logic [2:0] mode = 0;
  logic [7:0] itemCount = 0, itemData = 0, txByte = 0;
  logic busy, done, noPresence, itemReady, rxValid, dqIn, dqOut, dqOe, pull;
  logic [7:0] rxData, rxIndex, gotByte;
  logic [7:0] rxBuf [4];
  int err_total = 0, check_count = 0, cycles = 0, lowLen = 0, resets = 0;
  // Pulled-up line shared by both ends
  assign dqIn = (dqOe ? dqOut : 1'b1) & !pull;
  single_wire_bus_master #(.RESET_COUNT(4000), .PRESENCE_COUNT(800))
    single_wire_bus_master_i (.*);
  // One slave only, so read-id and skip-id are legal
  swire_slave swire_slave_i (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  // Received items, reset pulses and the cycle ceiling
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (rxValid) rxBuf[rxIndex[1:0]] <= rxData;
    lowLen <= dqOe ? lowLen + 1 : 0;
    if (!dqOe && lowLen > 3000) resets <= resets + 1;
    if (cycles == 90000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic run(input logic [2:0] md, input logic rd, input int n);
    int r0;
    @(negedge ref_clk);
    r0 = resets;
    mode = md;
    readOp = rd;
    itemCount = 8'(n);
    itemValid = !rd;
    start = 1;
    @(negedge ref_clk);
    start = 0;
    while (!done) @(negedge ref_clk);
    itemValid = 0;
    check("release", 8'(dqOe), 8'h00);
    repeat (2) @(negedge ref_clk);
    check("resets", 8'(resets - r0), 8'(md[0]) + 8'(md[1]));
  endtask : run
  task automatic write_test;
    itemData = 8'hCC;
    run(3'h1, 0, 1);
    check("written", gotByte, 8'hCC);
    check("presence", 8'(noPresence), 8'h00);
    $display("write test done");
  endtask : write_test
  task automatic bit_test;
    talk = 1;
    txByte = 8'h02;
    run(3'h6, 1, 2);
    check("bit0", rxBuf[0], 8'h00);
    check("bit1", rxBuf[1], 8'h01);
    $display("bit test done");
  endtask : bit_test
  task automatic byte_test;
    txByte = 8'h96;
    run(3'h3, 1, 1);
    check("byte", rxBuf[0], 8'h96);
    talk = 0;
    $display("byte test done");
  endtask : byte_test
  task automatic empty_test;
    run(3'h0, 0, 0);
    run(3'h4, 1, 0);
    $display("empty test done");
  endtask : empty_test
  task automatic abort_test;
    present = 0;
    rxBuf[0] = 8'h55;
    run(3'h5, 1, 1);
    check("abort", 8'(noPresence), 8'h01);
    check("no item", rxBuf[0], 8'h55);
    present = 1;
    $display("abort test done");
  endtask : abort_test
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_b = 1;
    repeat (4) @(negedge ref_clk);
    write_test();
    bit_test();
    byte_test();
    empty_test();
    abort_test();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
